// ### common/bsp_pkg.sv
package bsp_pkg;

    // ----------------------------------------------------------------
    // strap decoding
    // ----------------------------------------------------------------
    localparam logic [3:0] BUS_MODE_BIG_BYTE = 4'hb;
    localparam int STRAP_W = 8;
    localparam int STRAP_MODE_LO_POS = 0;
    localparam int STRAP_GPIO_POS = 3;
    localparam int STRAP_ENDIAN_POS = 4;
    localparam int STRAP_POL_POS = 5;
    localparam int STRAP_DIV_POS = 6;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REVISION_CODE_OFS = 17'h00000;
    localparam int DISPLAY_BUF_BYTES = 80 * 1024;

    // ----------------------------------------------------------------
    // reset and timing
    // ----------------------------------------------------------------
    // two cycles for the strap levels to pass the synchroniser
    localparam logic [1:0] CFG_SETTLE_CYCLES = 2'h2;
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [7:0] REVISION_CODE_RESET = 8'h5a;

    typedef struct packed {
        logic mode_ok;
        logic big_endian;
        logic gpio_inputs;
        logic wait_high;
        logic [1:0] div;
    } bsp_cfg_t;

    typedef struct packed {
        logic cs_n;
        logic mem_sel;
        logic we_hi_n;
        logic we_lo_n;
        logic rd_hi_n;
        logic rd_lo_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRAP_W-1:0] straps;
    } bsp_pins_t;

    typedef enum logic [1:0] {
        ST_CFG,
        ST_IDLE,
        ST_ARB,
        ST_DONE
    } bsp_state_t;

endpackage : bsp_pkg

// ### sim/bsp_host_model.sv
`timescale 1ns/1ps
module bsp_host_model import bsp_pkg::*; (
    input wire logic clk,
    input wire logic holdoff,
    input wire logic wait_high,
    input wire logic data_oe,
    input wire logic [DATA_W-1:0] data_out,
    output bsp_pins_t p,
    output logic bus_start_n
);
    // ----------------------------------------
    // single-beat chip-select host
    // ----------------------------------------
    // one call is one uncached beat, issued in program order
    assign bus_start_n = 1'b1;
    initial p = '1;

    task automatic access(input logic wr, input logic msel, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [1:0] ln, output logic [DATA_W-1:0] q,
        output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        p.cs_n = 1'b0;
        p.mem_sel = msel;
        p.addr = a;
        p.data = wr ? d : ~p.data;
        p.we_hi_n = !(wr && ln[1]);
        p.we_lo_n = !(wr && ln[0]);
        p.rd_hi_n = wr;
        p.rd_lo_n = wr;
        while (holdoff !== wait_high && n < 20) begin
            @(negedge clk);
            n++;
        end
        ok = (holdoff === wait_high);
        while (holdoff === wait_high && n < 600) begin
            @(negedge clk);
            n++;
        end
        ok = ok && (holdoff === !wait_high);
        // no pull on the bus: an undriven read shows the inverse of the last level
        q = data_oe ? data_out : ~p.data;
        {p.cs_n, p.we_hi_n, p.we_lo_n, p.rd_hi_n, p.rd_lo_n} = 5'h1f;
        p.data = ~p.data;
        repeat (4) @(negedge clk);
    endtask : access
endmodule : bsp_host_model

// ### sim/byte_strobe_host_bus_port_tb_top.sv
`timescale 1ns/1ps
module byte_strobe_host_bus_port_tb_top import bsp_pkg::*; ();
    typedef struct packed {
        logic wr;
        logic msel;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [1:0] ln;
        logic [DATA_W-1:0] exp;
    } bsp_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [STRAP_W-1:0] straps = 8'h33;
    logic pol = 1'b1;
    logic disp_req = 1'b0;
    bsp_pins_t pins;
    logic bstart_n;
    logic [DATA_W-1:0] dout;
    logic oe;
    logic hold;
    logic gpio_en;
    logic [DATA_W-1:0] q;
    logic ok;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    // last in-range word, then the first word past the buffer
    bsp_row_t rows [14] = '{
        '{1'b1, 1'b1, 17'h00002, 16'h1234, 2'h3, 16'h0000},
        '{1'b0, 1'b1, 17'h00002, 16'h0000, 2'h3, 16'h1234},
        '{1'b1, 1'b1, 17'h00002, 16'h00ab, 2'h1, 16'h0000},
        '{1'b0, 1'b1, 17'h00002, 16'h0000, 2'h3, 16'h12ab},
        '{1'b1, 1'b1, 17'h00002, 16'hcd77, 2'h2, 16'h0000},
        '{1'b0, 1'b1, 17'h00002, 16'h0000, 2'h3, 16'hcdab},
        '{1'b1, 1'b1, 17'h13ffe, 16'hbeef, 2'h3, 16'h0000},
        '{1'b0, 1'b1, 17'h13ffe, 16'h0000, 2'h3, 16'hbeef},
        '{1'b1, 1'b0, 17'h00000, 16'hffff, 2'h3, 16'h0000},
        '{1'b0, 1'b0, 17'h00000, 16'h0000, 2'h3, 16'h5a00},
        '{1'b0, 1'b0, 17'h00000, 16'h0000, 2'h3, 16'h5a00},
        '{1'b1, 1'b1, 17'h14000, 16'h5555, 2'h3, 16'h0000},
        '{1'b0, 1'b1, 17'h14000, 16'h0000, 2'h3, 16'h0000},
        '{1'b0, 1'b0, 17'h00002, 16'h0000, 2'h3, 16'h0000}};

    bsp_host_port dut (.CLK(clk), .NRST(nrst), .STRAPS(straps), .CS_N(pins.cs_n),
        .MEM_REG_SEL(pins.mem_sel), .HOST_ADDRESS_IN(pins.addr), .HOST_DATA_IN(pins.data),
        .LOW_BYTE_WRITE_N(pins.we_lo_n), .HIGH_BYTE_WRITE_N(pins.we_hi_n),
        .LOW_BYTE_READ_N(pins.rd_lo_n), .HIGH_BYTE_READ_N(pins.rd_hi_n),
        .BUS_START_STROBE_N(bstart_n), .DISPLAY_REQ(disp_req), .HOST_DATA_OUT(dout),
        .HOST_DATA_OE(oe), .HOLDOFF(hold), .GPIO_OUTPUT_EN(gpio_en));
    bsp_host_model host (.clk(clk), .holdoff(hold), .wait_high(pol), .data_oe(oe),
        .data_out(dout), .p(pins), .bus_start_n(bstart_n));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // straps held steady well past release so the synchroniser sees them
    task automatic do_reset(input logic [STRAP_W-1:0] s, input logic pl);
        @(negedge clk);
        nrst = 1'b0;
        straps = s;
        pol = pl;
        repeat (5) @(negedge clk);
        check({hold, gpio_en, oe}, 3'h0);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        check(hold, !pl);
    endtask : do_reset

    initial begin
        do_reset(8'h33, 1'b1);
        check(gpio_en, 1'b1);
        foreach (rows[i]) begin
            host.access(rows[i].wr, rows[i].msel, rows[i].a, rows[i].d, rows[i].ln, q, ok);
            check(ok, 1'b1);
            if (rows[i].wr === 1'b0)
                check(q, rows[i].exp);
        end
        disp_req = 1'b1;
        fork
            host.access(1'b0, 1'b1, 17'h00002, 16'h0000, 2'h3, q, ok);
            begin
                repeat (12) @(negedge clk);
                check(hold, 1'b1);
                disp_req = 1'b0;
            end
        join
        check(q, 16'hcdab);
        host.p.rd_lo_n = 1'b0;
        host.p.rd_hi_n = 1'b0;
        host.p.we_lo_n = 1'b0;
        repeat (6) @(negedge clk);
        check({hold, oe}, 2'h0);
        {host.p.we_lo_n, host.p.rd_hi_n, host.p.rd_lo_n} = 3'h7;
        host.access(1'b0, 1'b1, 17'h00002, 16'h0000, 2'h3, q, ok);
        check(q, 16'hcdab);
        do_reset(8'hdb, 1'b0);
        check(gpio_en, 1'b0);
        straps = 8'h00;
        host.access(1'b0, 1'b0, 17'h00000, 16'h0000, 2'h3, q, ok);
        check({ok, q}, {1'b1, 16'h5a00});
        // wrong mode straps with the 2:1 divider, so the tick cadence is watched too
        do_reset(8'h63, 1'b1);
        host.access(1'b0, 1'b0, 17'h00000, 16'h0000, 2'h3, q, ok);
        check({ok, oe}, 2'h0);
        end_of_test();
    end
endmodule : byte_strobe_host_bus_port_tb_top

// ### verilog/bsp_host_port.sv
`timescale 1ns/1ps
// What this block does
// - straps are caught on the third clock after reset release; bus pins act only after that
// - bus mode straps 1011 enable the big-endian byte-strobe bus
// - endian strap set selects big-endian byte lanes
// - gpio strap high makes gpio inputs, low makes them panel outputs
// - polarity strap high gives active-high hold-off, low gives active-low
// - the input clock, divided 1:1 to 4:1 by the divider straps, drives internal bus and memory timing
// - host sees a 16-bit data bus and 17-bit address
// - memory/register select routes access to registers or display buffer
// - select low hits register block, high hits 80K display buffer
// - only byte lanes whose write strobe is low are updated
// - either read strobe low marks a read and drives both byte lanes
// - hold-off stays active until read data ready or write accepted
// - hold-off covers contention with display update until arbitration ends
// - releasing hold-off ends the cycle, acting as transfer acknowledge
// - read-only revision code at register offset 00h, stable on rereads
module bsp_host_port import bsp_pkg::*; #(
    parameter logic [7:0] REVISION_CODE = REVISION_CODE_RESET, // arbitrary value
    parameter int MEM_BYTES = DISPLAY_BUF_BYTES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [STRAP_W-1:0] STRAPS,
    input wire logic CS_N,
    input wire logic MEM_REG_SEL,
    input wire logic [ADDR_W-1:0] HOST_ADDRESS_IN,
    input wire logic [DATA_W-1:0] HOST_DATA_IN,
    input wire logic LOW_BYTE_WRITE_N,
    input wire logic HIGH_BYTE_WRITE_N,
    input wire logic LOW_BYTE_READ_N,
    input wire logic HIGH_BYTE_READ_N,
    input wire logic BUS_START_STROBE_N,
    input wire logic DISPLAY_REQ,
    output logic [DATA_W-1:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    output logic HOLDOFF,
    output logic GPIO_OUTPUT_EN
);

    localparam int MEM_WORDS = MEM_BYTES / 2;
    localparam int WIDX_W = ADDR_W - 1;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    // the bus start pin is tied high in this mode and is not looked at
    bsp_pins_t pins_raw;
    bsp_pins_t sync1;
    bsp_pins_t sync2;

    always_comb begin
        pins_raw = '{cs_n: CS_N, mem_sel: MEM_REG_SEL, we_hi_n: HIGH_BYTE_WRITE_N,
                     we_lo_n: LOW_BYTE_WRITE_N, rd_hi_n: HIGH_BYTE_READ_N,
                     rd_lo_n: LOW_BYTE_READ_N, addr: HOST_ADDRESS_IN,
                     data: HOST_DATA_IN, straps: STRAPS};
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
        end
    end

    // ----------------------------------------------------------------
    // lane mapping helpers
    // ----------------------------------------------------------------
    function automatic logic [DATA_W-1:0] to_bus(input logic [7:0] even,
                                                 input logic [7:0] odd,
                                                 input logic big);
        to_bus = big ? {even, odd} : {odd, even};
    endfunction : to_bus

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bsp_state_t state, next_state;
    bsp_cfg_t cfg, next_cfg;
    logic [1:0] settle, next_settle;
    logic [1:0] div_cnt, next_div_cnt;
    logic busy, next_busy;
    logic [DATA_W-1:0] next_data_out;
    logic next_data_oe;
    logic next_holdoff;
    logic next_gpio_oe;

    logic cfg_done;
    logic tick;
    logic acc;
    logic is_read;
    logic grant;
    logic [WIDX_W-1:0] widx;
    logic in_mem;
    logic [7:0] rd_even, rd_odd;
    logic wr_even, wr_odd;
    logic [7:0] wd_even, wd_odd;

    logic [7:0] mem_even [MEM_WORDS];
    logic [7:0] mem_odd [MEM_WORDS];

    always_comb begin
        cfg_done = (state != ST_CFG);
        // host bus activity only counts while selected
        acc = !sync2.cs_n && !(sync2.we_hi_n && sync2.we_lo_n &&
                               sync2.rd_hi_n && sync2.rd_lo_n);
        // both read strobes arrive together; either one marks a read
        is_read = !(sync2.rd_hi_n && sync2.rd_lo_n);
        tick = (div_cnt == cfg.div);
        // refresh owns the buffer while it asks; host waits its turn
        grant = (state == ST_ARB) && !sync2.cs_n && tick && !DISPLAY_REQ;
        widx = sync2.addr[ADDR_W-1:1];
        in_mem = sync2.mem_sel && (int'(widx) < MEM_WORDS);
        rd_even = 8'h00;
        rd_odd = 8'h00;
        if (in_mem) begin
            rd_even = mem_even[widx];
            rd_odd = mem_odd[widx];
        end else if (!sync2.mem_sel && (sync2.addr == REVISION_CODE_OFS)) begin
            rd_even = REVISION_CODE;
        end
        // big-endian puts the even byte on the high lane
        wr_even = cfg.big_endian ? !sync2.we_hi_n : !sync2.we_lo_n;
        wr_odd = cfg.big_endian ? !sync2.we_lo_n : !sync2.we_hi_n;
        wd_even = cfg.big_endian ? sync2.data[15:8] : sync2.data[7:0];
        wd_odd = cfg.big_endian ? sync2.data[7:0] : sync2.data[15:8];
    end

    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_settle = settle;
        next_div_cnt = tick ? DIV_RESET : div_cnt + 2'h1;
        next_busy = busy;
        next_data_out = HOST_DATA_OUT;
        next_data_oe = HOST_DATA_OE && acc && is_read;
        next_gpio_oe = GPIO_OUTPUT_EN;
        case (state)
            ST_CFG: begin
                next_div_cnt = DIV_RESET;
                next_settle = settle + 2'h1;
                if (settle == CFG_SETTLE_CYCLES) begin
                    next_cfg.mode_ok = ({sync2.straps[STRAP_ENDIAN_POS],
                        sync2.straps[STRAP_MODE_LO_POS+2:STRAP_MODE_LO_POS]}
                        == BUS_MODE_BIG_BYTE);
                    next_cfg.big_endian = sync2.straps[STRAP_ENDIAN_POS];
                    next_cfg.gpio_inputs = sync2.straps[STRAP_GPIO_POS];
                    next_cfg.wait_high = sync2.straps[STRAP_POL_POS];
                    next_cfg.div = sync2.straps[STRAP_DIV_POS+1:STRAP_DIV_POS];
                    next_gpio_oe = !sync2.straps[STRAP_GPIO_POS];
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (acc && cfg.mode_ok) begin
                    next_busy = 1'b1;
                    next_state = ST_ARB;
                end
            end
            ST_ARB: begin
                if (sync2.cs_n) begin
                    next_busy = 1'b0;
                    next_state = ST_IDLE;
                end else if (grant) begin
                    next_busy = 1'b0;
                    if (is_read) begin
                        next_data_out = to_bus(rd_even, rd_odd, cfg.big_endian);
                        next_data_oe = 1'b1;
                    end
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // no new cycle until the strobes of this one are gone
                if (!acc) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
            end
        endcase
        next_holdoff = 1'b0;
        if (next_state != ST_CFG) begin
            next_holdoff = next_busy ? next_cfg.wait_high : !next_cfg.wait_high;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= ST_CFG;
            cfg <= '0;
            settle <= 2'h0;
            div_cnt <= DIV_RESET;
            busy <= 1'b0;
            HOST_DATA_OUT <= 16'h0000;
            HOST_DATA_OE <= 1'b0;
            HOLDOFF <= 1'b0;
            GPIO_OUTPUT_EN <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            settle <= next_settle;
            div_cnt <= next_div_cnt;
            busy <= next_busy;
            HOST_DATA_OUT <= next_data_out;
            HOST_DATA_OE <= next_data_oe;
            HOLDOFF <= next_holdoff;
            GPIO_OUTPUT_EN <= next_gpio_oe;
        end
    end

    // ----------------------------------------------------------------
    // display buffer
    // ----------------------------------------------------------------
    // kept without reset: contents are undefined after power-up anyway
    always_ff @(posedge CLK) begin
        if (grant && !is_read && in_mem) begin
            if (wr_even) begin
                mem_even[widx] <= wd_even;
            end
            if (wr_odd) begin
                mem_odd[widx] <= wd_odd;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_fast_tick;
        tick ##1 !tick ##1 tick;
    endsequence

    property p_cfg_stable;
        @(posedge CLK) disable iff (!NRST) cfg_done |=> $stable(cfg);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable)
        else $error("strap configuration changed after latch");

    property p_cfg_quiet;
        @(posedge CLK) disable iff (!NRST) !cfg_done |-> !HOST_DATA_OE && !HOLDOFF;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet)
        else $error("bus pins active before configuration");

    property p_mode_gate;
        @(posedge CLK) disable iff (!NRST)
            (state == ST_IDLE && acc && !cfg.mode_ok) |=> state == ST_IDLE;
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("access served in wrong bus mode");

    property p_endian_read;
        @(posedge CLK) disable iff (!NRST)
            (grant && is_read && cfg.big_endian) |=> HOST_DATA_OUT[15:8] == $past(rd_even);
    endproperty
    a_endian_read: assert property (p_endian_read)
        else $error("even byte not on high lane in big-endian");

    property p_gpio_dir;
        @(posedge CLK) disable iff (!NRST) cfg_done |-> GPIO_OUTPUT_EN == !cfg.gpio_inputs;
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("gpio direction disagrees with strap");

    property p_wait_pol;
        @(posedge CLK) disable iff (!NRST)
            cfg_done |-> HOLDOFF == (busy ? cfg.wait_high : !cfg.wait_high);
    endproperty
    a_wait_pol: assert property (p_wait_pol)
        else $error("hold-off polarity wrong");

    property p_div2;
        @(posedge CLK) disable iff (!NRST)
            (cfg_done && cfg.div == 2'h1 && tick) |-> s_fast_tick;
    endproperty
    a_div2: assert property (p_div2)
        else $error("2:1 bus clock cadence wrong");

    property p_byte_keep;
        @(posedge CLK) disable iff (!NRST)
            (grant && !is_read && in_mem && !wr_even) |=> rd_even == $past(rd_even);
    endproperty
    a_byte_keep: assert property (p_byte_keep)
        else $error("unstrobed byte lane modified");

    property p_hold_contend;
        @(posedge CLK) disable iff (!NRST)
            (state == ST_ARB && !sync2.cs_n && DISPLAY_REQ) |=> busy && state == ST_ARB;
    endproperty
    a_hold_contend: assert property (p_hold_contend)
        else $error("host released during display contention");

    property p_ack_end;
        @(posedge CLK) disable iff (!NRST) grant |=> !busy && state == ST_DONE;
    endproperty
    a_ack_end: assert property (p_ack_end)
        else $error("hold-off not released at end of cycle");

    property p_rev;
        @(posedge CLK) disable iff (!NRST)
            (grant && is_read && !sync2.mem_sel && sync2.addr == REVISION_CODE_OFS)
            |=> HOST_DATA_OUT == to_bus(REVISION_CODE, 8'h00, cfg.big_endian);
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision code read wrong");

    property p_cs_float;
        @(posedge CLK) disable iff (!NRST) sync2.cs_n |=> !HOST_DATA_OE;
    endproperty
    a_cs_float: assert property (p_cs_float)
        else $error("data bus driven while deselected");

endmodule : bsp_host_port
